/* ahb_host.sv */
`timescale 1ns/1ps
module ahb_host
(
  input wire logic clk_i, // Clock
  input wire logic hready_i, // Bus ready
  input wire logic [31:0] hrdata_i, // Read data
  output logic hsel_o = 1'b0, // Select
  output logic [7:0] haddr_o = 8'h00, // Address
  output logic [1:0] htrans_o = 2'h0, // Transfer type
  output logic hwrite_o = 1'b0, // Write
  output logic [2:0] hsize_o = 3'h2, // Word size
  output logic [31:0] hwdata_o = 32'h0 // Write data
);
  // One word transfer; each phase holds until ready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    hsel_o <= 1'b1;
    haddr_o <= a;
    htrans_o <= 2'h2;
    hwrite_o <= wr;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    hsel_o <= 1'b0;
    htrans_o <= 2'h0;
    hwdata_o <= d;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    r = hrdata_i;
    hwdata_o <= ~d; // Stale data must not look valid
  endtask
endmodule

/* supply_fault_monitor.sv */
// Added by the designer: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
// Overview of operation
// - Undervoltage sets summary and supply low flags
// - Normal mode: rewrite on bit after undervoltage
// - Supply low clears on read once gone
// - Fail mode restarts outputs automatically
// - Autorestart interval 64 ms nominal
// - Overvoltage sets summary and supply high flags
// - Supply high clears on read once gone
// - Supply faults deglitched 3.5 us nominal
// - Power-up: outputs off, commands held
// - Pump fault switches all outputs off
// - Pump fault sets summary and pump flags
// - Held command runs with overcurrent window
// - Pump flag clears on read once gone
// - Pump faults deglitched 4.0 us nominal
module supply_fault_monitor
  import supply_fault_pkg::*;
#(
  parameter int NCH = 6, // Number of power channels
  parameter int AUTO_CYC = AUTO_RESTART_CYC // Retry interval in cycles
)(
  input wire logic clk_sys_i, // System clock
  input wire logic rst_n_i, // Sync reset, active low
  input wire logic hsel_i, // AHB select
  input wire logic [7:0] haddr_i, // AHB address, low byte
  input wire logic [1:0] htrans_i, // AHB transfer type
  input wire logic hwrite_i, // AHB write
  input wire logic [2:0] hsize_i, // AHB size, word only
  input wire logic [31:0] hwdata_i, // AHB write data
  input wire logic hready_i, // AHB bus ready
  output logic [31:0] hrdata_o, // AHB read data
  output logic hreadyout_o, // AHB slave ready
  output logic hresp_o, // AHB response, always OKAY
  input wire logic uv_cmp_i, // Undervoltage comparator, async
  input wire logic ov_cmp_i, // Overvoltage comparator, async
  input wire logic cp_bad_i, // Pump out of range, async
  output logic [NCH-1:0] out_en_o, // Power output enables
  output logic [NCH-1:0] oc_window_o, // Start-up overcurrent window pulse
  output logic irq_o // Interrupt, level
);
  import supply_fault_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  cond_t sync1_q, sync2_q; // Two-stage synchroniser
  cond_t dgl_q, dgl_d; // Deglitched conditions
  logic [DGL_W-1:0] cnt_q [3]; // Deglitch counters
  logic [DGL_W-1:0] cnt_d [3];
  logic pump_seen_q, pump_seen_d; // Pump has settled since reset
  logic low_flag_q, low_flag_d; // Supply low
  logic high_flag_q, high_flag_d; // Supply high
  logic pump_flag_q, pump_flag_d; // Pump fault
  logic fail_mode_q, fail_mode_d; // Mode select
  logic [NCH-1:0] on_q, on_d; // Commanded on bits
  logic [NCH-1:0] out_q, out_d; // Driven enables
  logic [NCH-1:0] win_q, win_d; // Overcurrent window pulse
  logic hold_q, hold_d; // Fail mode restart pending
  logic [AUTO_W-1:0] auto_q, auto_d; // Autorestart timer
  logic [2:0] irq_st_q, irq_st_d; // Sticky events
  logic [2:0] irq_mask_q, irq_mask_d; // Event mask
  ahb_req_t req_q, req_d; // Data phase request
  logic [31:0] rdata_q, rdata_d; // Read data
  logic acc; // Address phase accepted
  logic rd_qs, rd_ds, rd_irq; // Read strobes, clearing
  logic summary; // Any supply or pump fault latched
  logic pump_bad; // Pump not usable
  logic [2:0] rise; // Deglitched rising edges
  logic [DGL_W-1:0] lim [3]; // Deglitch limits

  // ----------------------------------------
  // Synchroniser
  // ----------------------------------------
  // Comparators are asynchronous; only stage two is read
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      // Pump reads as bad until a real low has crossed both stages, so the
      // power-up gate cannot open on the reset value of the synchroniser
      sync1_q <= '{pump: 1'b1, high: 1'b0, low: 1'b0};
      sync2_q <= '{pump: 1'b1, high: 1'b0, low: 1'b0};
    end
    else
    begin
      sync1_q <= '{pump: cp_bad_i, high: ov_cmp_i, low: uv_cmp_i};
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------
  // Deglitch filters
  // ----------------------------------------
  assign lim[0] = DGL_W'(DGL_SUPPLY_CYC);
  assign lim[1] = DGL_W'(DGL_SUPPLY_CYC);
  assign lim[2] = DGL_W'(DGL_PUMP_CYC);

  // Condition asserts after it stays high for the full limit; a drop restarts the count
  always_comb
  begin
    dgl_d = dgl_q;
    pump_seen_d = pump_seen_q | ~sync2_q.pump;
    for (int i = 0; i < 3; i++)
    begin
      cnt_d[i] = cnt_q[i];
      if (!sync2_q[i])
      begin
        // Release immediately, restart the filter
        cnt_d[i] = '0;
        dgl_d[i] = 1'b0;
      end
      else if (cnt_q[i] < lim[i] - 1'b1)
      begin
        cnt_d[i] = cnt_q[i] + 1'b1;
      end
      else
      begin
        dgl_d[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      dgl_q <= '0;
      pump_seen_q <= 1'b0;
      for (int i = 0; i < 3; i++)
      begin
        cnt_q[i] <= '0;
      end
    end
    else
    begin
      dgl_q <= dgl_d;
      pump_seen_q <= pump_seen_d;
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  // Zero wait states; reads clear at the address phase so data and clear agree
  assign acc = hsel_i & hready_i & htrans_i[1];
  assign rd_qs = acc & ~hwrite_i & (haddr_i == QUICK_STAT_OFS);
  assign rd_ds = acc & ~hwrite_i & (haddr_i == DEV_STAT_OFS);
  assign rd_irq = acc & ~hwrite_i & (haddr_i == IRQ_STAT_OFS);
  assign summary = low_flag_q | high_flag_q | pump_flag_q;

  always_comb
  begin
    req_d = '{addr: haddr_i, wr: acc & hwrite_i, rd: acc & ~hwrite_i};
    rdata_d = '0;
    // Read data muxed in the address phase
    if (haddr_i == QUICK_STAT_OFS)
    begin
      rdata_d[SUMMARY_BIT] = summary;
      rdata_d[PUMP_BIT] = pump_flag_q;
    end
    else if (haddr_i == DEV_STAT_OFS)
    begin
      rdata_d[SUMMARY_BIT] = summary;
      rdata_d[LOW_BIT] = low_flag_q;
      rdata_d[HIGH_BIT] = high_flag_q;
    end
    else if (haddr_i == MODE_CTRL_OFS)
    begin
      rdata_d[FAIL_MODE_BIT] = fail_mode_q;
    end
    else if (haddr_i == OUT_CTRL_OFS)
    begin
      rdata_d[NCH-1:0] = on_q;
      rdata_d[NCH+7:8] = out_q; // Actual drive state
    end
    else if (haddr_i == IRQ_STAT_OFS)
    begin
      rdata_d[2:0] = irq_st_q;
    end
    else if (haddr_i == IRQ_MASK_OFS)
    begin
      rdata_d[2:0] = irq_mask_q;
    end
    else
    begin
      // Unmapped reads return zero
      rdata_d = '0;
    end
    if (!(acc & ~hwrite_i))
    begin
      rdata_d = rdata_q;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      req_q <= '0;
      rdata_q <= '0;
    end
    else
    begin
      req_q <= req_d;
      rdata_q <= rdata_d;
    end
  end

  assign hrdata_o = rdata_q;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  // ----------------------------------------
  // Fault flags and events
  // ----------------------------------------
  // A live condition always wins over a clearing read of a flag; for an event bit only a rise in the same cycle does
  always_comb
  begin
    low_flag_d = dgl_q.low | (low_flag_q & ~rd_ds);
    high_flag_d = dgl_q.high | (high_flag_q & ~rd_ds);
    pump_flag_d = dgl_q.pump | (pump_flag_q & ~rd_qs);
    rise = dgl_d & ~dgl_q;
    irq_st_d = rise | (irq_st_q & ~{3{rd_irq}});
    irq_mask_d = irq_mask_q;
    fail_mode_d = fail_mode_q;
    if (req_q.wr && req_q.addr == IRQ_MASK_OFS)
    begin
      irq_mask_d = hwdata_i[2:0];
    end
    if (req_q.wr && req_q.addr == MODE_CTRL_OFS)
    begin
      fail_mode_d = hwdata_i[FAIL_MODE_BIT];
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      low_flag_q <= 1'b0;
      high_flag_q <= 1'b0;
      pump_flag_q <= 1'b0;
      irq_st_q <= '0;
      irq_mask_q <= IRQ_MASK_RST;
      fail_mode_q <= FAIL_MODE_RST;
    end
    else
    begin
      low_flag_q <= low_flag_d;
      high_flag_q <= high_flag_d;
      pump_flag_q <= pump_flag_d;
      irq_st_q <= irq_st_d;
      irq_mask_q <= irq_mask_d;
      fail_mode_q <= fail_mode_d;
    end
  end

  assign irq_o = |(irq_st_q & irq_mask_q);

  // ----------------------------------------
  // Output control
  // ----------------------------------------
  assign pump_bad = dgl_q.pump | ~pump_seen_q;

  // On bits survive pump faults, so a held command runs once the pump is valid
  always_comb
  begin
    on_d = on_q;
    hold_d = hold_q;
    auto_d = auto_q;
    if (req_q.wr && req_q.addr == OUT_CTRL_OFS && !dgl_q.low)
    begin
      on_d = hwdata_i[NCH-1:0];
    end
    if (dgl_q.low && !fail_mode_q)
    begin
      // Normal mode: host must rewrite the on bits
      on_d = '0;
    end
    if (fail_mode_q)
    begin
      if (dgl_q.low)
      begin
        hold_d = 1'b1;
        auto_d = '0;
      end
      else if (hold_q && auto_q < AUTO_W'(AUTO_CYC - 1))
      begin
        auto_d = auto_q + 1'b1;
      end
      else
      begin
        hold_d = 1'b0;
        auto_d = '0;
      end
    end
    else
    begin
      hold_d = 1'b0;
      auto_d = '0;
    end
    out_d = on_q;
    if (pump_bad || dgl_q.low || hold_q)
    begin
      out_d = '0;
    end
    win_d = out_d & ~out_q;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      on_q <= '0;
      out_q <= '0;
      win_q <= '0;
      hold_q <= 1'b0;
      auto_q <= '0;
    end
    else
    begin
      on_q <= on_d;
      out_q <= out_d;
      win_q <= win_d;
      hold_q <= hold_d;
      auto_q <= auto_d;
    end
  end

  assign out_en_o = out_q;
  assign oc_window_o = win_q;
endmodule

/* supply_fault_monitor_props.sv */
`timescale 1ns/1ps
module supply_fault_monitor_props
  import supply_fault_pkg::*;
#(
  parameter int NCH = 6, // Channels
  parameter int AUTO_CYC = 50 // Retry cycles
)(
  input wire logic clk_sys_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic hsel_i, // Select
  input wire logic [1:0] htrans_i, // Transfer type
  input wire logic hwrite_i, // Write
  input wire logic hready_i, // Bus ready
  input wire logic [31:0] hrdata_o, // Read data
  input wire logic hreadyout_o, // Slave ready
  input wire logic hresp_o, // Response
  input wire logic uv_cmp_i, // Low supply pin
  input wire logic cp_bad_i, // Pump pin
  input wire logic [NCH-1:0] out_en_o, // Enables
  input wire logic [NCH-1:0] oc_window_o, // Window pulse
  input wire logic irq_o // Interrupt
);
  // Run length of each raw pin, saturating; sync and filter lag are allowed for
  logic [7:0] uv_n_q, uv_n_d, cp_n_q, cp_n_d;
  always_comb
  begin
    uv_n_d = uv_cmp_i ? uv_n_q + {7'h00, uv_n_q != 8'hFF} : 8'h00;
    cp_n_d = cp_bad_i ? cp_n_q + {7'h00, cp_n_q != 8'hFF} : 8'h00;
  end
  always_ff @(posedge clk_sys_i)
  begin
    uv_n_q <= rst_n_i ? uv_n_d : 8'h00;
    cp_n_q <= rst_n_i ? cp_n_d : 8'h00;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  a_ready_one: assert property (hreadyout_o == 1'b1) else $error("slave stalled");
  a_resp_okay: assert property (hresp_o == 1'b0) else $error("error response");
  a_rdata_stand: assert property (!(hsel_i && hready_i && htrans_i[1] && !hwrite_i) |=> $stable(hrdata_o))
    else $error("read data moved");
  a_uv_off:
    assert property (uv_n_q >= 8'h5F |-> out_en_o == '0) else $error("on in low supply");
  a_pump_off:
    assert property (cp_n_q >= 8'h6B |-> out_en_o == '0) else $error("on in pump fault");
  a_window_edge:
    assert property (oc_window_o == (out_en_o & ~$past(out_en_o))) else $error("bad window");
  a_window_quiet:
    assert property (uv_n_q >= 8'h5F || cp_n_q >= 8'h6B |-> oc_window_o == '0) else $error("window in fault");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n_i |=> out_en_o == '0 && oc_window_o == '0 && !irq_o)
    else $error("active in reset");
endmodule
bind supply_fault_monitor supply_fault_monitor_props #(.NCH(NCH), .AUTO_CYC(AUTO_CYC)) supply_fault_monitor_props_inst (
  .clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i),
  .hsel_i(hsel_i),
  .htrans_i(htrans_i),
  .hwrite_i(hwrite_i),
  .hready_i(hready_i),
  .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o),
  .uv_cmp_i(uv_cmp_i),
  .cp_bad_i(cp_bad_i),
  .out_en_o(out_en_o),
  .oc_window_o(oc_window_o),
  .irq_o(irq_o)
);

/* supply_fault_pkg.sv */
package supply_fault_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40; // 25 MHz system clock
  localparam int DGL_SUPPLY_NS = 3500; // Supply deglitch, nominal
  localparam int DGL_PUMP_NS = 4000; // Pump deglitch, nominal
  localparam int AUTO_RESTART_MS = 64; // Fail mode retry interval
  localparam int DGL_SUPPLY_CYC = (DGL_SUPPLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DGL_PUMP_CYC = (DGL_PUMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AUTO_RESTART_CYC = AUTO_RESTART_MS * 1000000 / CLK_PERIOD_NS;
  localparam int DGL_W = 8; // Deglitch counter width
  localparam int AUTO_W = 24; // Autorestart counter width

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] QUICK_STAT_OFS = 8'h00; // Quick status
  localparam logic [7:0] DEV_STAT_OFS = 8'h04; // Device status
  localparam logic [7:0] MODE_CTRL_OFS = 8'h08; // Mode control
  localparam logic [7:0] OUT_CTRL_OFS = 8'h0C; // Output on bits
  localparam logic [7:0] IRQ_STAT_OFS = 8'h10; // Sticky events
  localparam logic [7:0] IRQ_MASK_OFS = 8'h14; // Event mask

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SUMMARY_BIT = 0; // Device fault summary, both status regs
  localparam int PUMP_BIT = 1; // Pump fault in quick status
  localparam int LOW_BIT = 1; // Supply low in device status
  localparam int HIGH_BIT = 2; // Supply high in device status
  localparam int FAIL_MODE_BIT = 0; // Mode control: 1 = fail mode
  localparam int EV_LOW_BIT = 0; // Event bits, status and mask
  localparam int EV_HIGH_BIT = 1;
  localparam int EV_PUMP_BIT = 2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  localparam logic FAIL_MODE_RST = 1'b0;

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic pump; // Charge pump out of range
    logic high; // Battery overvoltage
    logic low; // Battery undervoltage
  } cond_t;

  typedef struct packed {
    logic [7:0] addr; // Latched byte address
    logic wr; // Write transfer
    logic rd; // Read transfer
  } ahb_req_t;
endpackage

/* tb_supply_fault_monitor.sv */
`timescale 1ns/1ps
module tb_supply_fault_monitor;
  import supply_fault_pkg::*;
  localparam int AUTO = 50; // Short retry interval
  localparam cond_t UV = 3'h1;
  localparam cond_t OV = 3'h2;
  localparam cond_t CP = 3'h4;
  localparam cond_t NO = 3'h0;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  cond_t cond = CP; // Pump not settled at power-up
  logic hsel, hwrite, hready, hresp, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] haddr;
  logic [31:0] hwdata, hrdata;
  logic [5:0] out_en, oc_win;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  always #20 clk_sys_i = ~clk_sys_i;
  ahb_host ahb_host_inst (.clk_i(clk_sys_i), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));
  supply_fault_monitor #(.NCH(6), .AUTO_CYC(AUTO)) supply_fault_monitor_inst (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .uv_cmp_i(cond.low), .ov_cmp_i(cond.high), .cp_bad_i(cond.pump), .out_en_o(out_en),
    .oc_window_o(oc_win), .irq_o(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb_host_inst.xfer(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb_host_inst.xfer(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  // Comparator pattern set at an edge, kept k cycles, then settled
  task automatic hold(input cond_t c, input int k);
    @(posedge clk_sys_i);
    cond <= c;
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask
  // Bounded wait for the enables; n counts cycles taken
  task automatic wait_out(input logic [5:0] e);
    n = 0;
    while (out_en !== e && n < 200)
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    chk(32'(out_en), 32'(e));
  endtask
  task automatic t_power;
    rdc(IRQ_MASK_OFS, 32'(IRQ_MASK_RST));
    rdc(MODE_CTRL_OFS, 32'(FAIL_MODE_RST));
    rdc(8'h20, 32'h0);
    wr(OUT_CTRL_OFS, 32'h3F);
    hold(CP, 4);
    chk(32'(out_en), 32'h0);
    hold(NO, 0);
    wait_out(6'h3F);
    chk(32'(oc_win), 32'h3F);
  endtask
  task automatic t_uv;
    wr(IRQ_MASK_OFS, 32'h1);
    rdc(IRQ_MASK_OFS, 32'h1);
    hold(UV, 60);
    hold(NO, 5);
    chk(32'(out_en), 32'h3F);
    rdc(DEV_STAT_OFS, 32'h0);
    hold(UV, 100);
    chk(32'(out_en), 32'h0);
    chk(32'(irq), 32'h1);
    rdc(DEV_STAT_OFS, 32'h3);
    rdc(QUICK_STAT_OFS, 32'h1);
    rdc(DEV_STAT_OFS, 32'h3);
    hold(NO, 10);
    chk(32'(out_en), 32'h0);
    rdc(DEV_STAT_OFS, 32'h3);
    rdc(DEV_STAT_OFS, 32'h0);
    rdc(IRQ_STAT_OFS, 32'h1);
    chk(32'(irq), 32'h0);
    wr(OUT_CTRL_OFS, 32'h15);
    wait_out(6'h15);
    rdc(OUT_CTRL_OFS, 32'h1515);
  endtask
  task automatic t_ov;
    hold(OV, 100);
    chk(32'(out_en), 32'h15);
    rdc(DEV_STAT_OFS, 32'h5);
    rdc(QUICK_STAT_OFS, 32'h1);
    hold(NO, 5);
    chk(32'(irq), 32'h0);
    rdc(DEV_STAT_OFS, 32'h5);
    rdc(DEV_STAT_OFS, 32'h0);
    rdc(IRQ_STAT_OFS, 32'h2);
  endtask
  task automatic t_pump;
    hold(CP, 90);
    hold(NO, 5);
    chk(32'(out_en), 32'h15);
    rdc(QUICK_STAT_OFS, 32'h0);
    hold(CP, 110);
    chk(32'(out_en), 32'h0);
    rdc(QUICK_STAT_OFS, 32'h3);
    rdc(DEV_STAT_OFS, 32'h1);
    wr(OUT_CTRL_OFS, 32'h2A);
    hold(NO, 0);
    wait_out(6'h2A);
    chk(32'(oc_win), 32'h2A);
    @(posedge clk_sys_i);
    #1;
    chk(32'(oc_win), 32'h0);
    rdc(QUICK_STAT_OFS, 32'h3);
    rdc(QUICK_STAT_OFS, 32'h0);
    rdc(IRQ_STAT_OFS, 32'h4);
  endtask
  task automatic t_fail;
    wr(MODE_CTRL_OFS, 32'h1);
    rdc(MODE_CTRL_OFS, 32'h1);
    hold(UV, 100);
    chk(32'(out_en), 32'h0);
    hold(NO, 0);
    wait_out(6'h2A);
    chk(32'(n >= AUTO && n <= AUTO + 10), 32'h1);
    rdc(DEV_STAT_OFS, 32'h3);
    rdc(IRQ_STAT_OFS, 32'h1);
  endtask
  task automatic t_rst;
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    #1;
    chk(32'(out_en), 32'h0);
    rdc(MODE_CTRL_OFS, 32'(FAIL_MODE_RST));
  endtask
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      complete_run;
    end
  end
  initial
  begin
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_power;
    t_uv;
    t_ov;
    t_pump;
    t_fail;
    t_rst;
    complete_run;
  end
endmodule
